// [src/windowed_watchdog_timer.sv]
// Windowed key-protected watchdog with write-once mode and read-clear status.
// How it works
// - Control write needs unlock key in top byte.
// - Keyed restart bit one restarts the watchdog.
// - Mode register accepts only its first write.
// - Reload value loads the 12-bit counter.
// - Fault irq enable routes faults to interrupt.
// - Fault reset enable routes faults to reset.
// - Scope bit picks processor or all resets.
// - Restart only when counter within window.
// - Early restart flags window error instead.
// - Debug halt stops counter in debug.
// - Idle halt stops counter when idle.
// - Disable bit stops the watchdog timer.
// - Underflow flag sticky until status read.
// - Window error flag sticky until read.
// - Counter ticks on slow clock divided 128.
// - Restart reloads counter and clears prescaler.
// - Underflow sets flag and fault if enabled.
// - Status read clears flags, irq, fault.
//
// The strobed register port was decided locally.
`default_nettype none
module windowed_watchdog_timer
	import wdog_pkg::*;
(
	input wire logic clock, // System clock, 125 MHz.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic slck_en, // Slow clock enable pulse.
	input wire logic debug_state, // Processor in debug, async.
	input wire logic idle_state, // System idle, async.
	input wire logic [3:0] addr, // Register byte address.
	input wire logic [31:0] wdata, // Write data.
	input wire logic wr, // Write strobe.
	input wire logic rd, // Read strobe.
	output logic [31:0] rdata, // Read data, cycle after rd.
	output logic irq, // Fault interrupt.
	output logic fault, // Fault to reset controller.
	output logic proc_reset_only // Fault asks processor reset only.
);
	// ************************************************
	// Input synchronisers and register decode
	// ************************************************
	logic dbg_s1_r, dbg_s2_r, idle_s1_r, idle_s2_r;
	always_ff @(posedge clock)
	begin
		dbg_s1_r <= debug_state;
		dbg_s2_r <= dbg_s1_r;
		idle_s1_r <= idle_state;
		idle_s2_r <= idle_s1_r;
	end

	logic [31:0] mode_r;
	logic mode_locked_r;
	logic [FIELD_W-1:0] count_r;
	logic unf_r, err_r;
	logic wr_ctrl, wr_mode, rd_stat, key_ok, restart_req, in_window, restart_ok;
	logic run, tick, underflow, win_err, prescale_clr;
	logic [FIELD_W-1:0] reload_v, window_v;

	assign reload_v = mode_r[RELOAD_LSB +: FIELD_W];
	assign window_v = mode_r[WINDOW_LSB +: FIELD_W];
	assign wr_ctrl = wr && (addr == OFF_RESTART_CONTROL);
	assign wr_mode = wr && (addr == OFF_WATCHDOG_MODE) && !mode_locked_r;
	assign rd_stat = rd && (addr == OFF_FAULT_STATUS);
	assign key_ok = (wdata[KEY_LSB +: 8] == UNLOCK_VALUE);
	assign restart_req = wr_ctrl && key_ok && wdata[RESTART_BIT];
	assign in_window = (count_r <= window_v);
	assign restart_ok = restart_req && in_window;
	// Window errors count even while disabled, so a stuck loop is still caught.
	assign win_err = restart_req && !in_window;
	// A mode write also restarts, matching the reload-on-program behaviour.
	assign prescale_clr = restart_ok || wr_mode;

	// The mode fields follow the lock so a new write takes effect at once.
	assign run = !mode_r[DISABLE_BIT]
		&& !(mode_r[DBG_HALT_BIT] && dbg_s2_r)
		&& !(mode_r[IDLE_HALT_BIT] && idle_s2_r);

	slow_tick u_prescale (
		.clock(clock),
		.srst(srst),
		.slck_en(slck_en),
		.run(run),
		.restart(prescale_clr),
		.tick(tick)
	);

	assign underflow = tick && (count_r == '0) && !prescale_clr;

	// ************************************************
	// Mode register, write once
	// ************************************************
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			mode_r <= MODE_RESET;
			mode_locked_r <= 1'b0;
		end
		else if (wr_mode)
		begin
			mode_r <= wdata & MODE_MASK;
			mode_locked_r <= 1'b1;
		end
	end

	// ************************************************
	// Down counter
	// ************************************************
	always_ff @(posedge clock)
	begin
		if (srst)
			count_r <= MODE_RESET[RELOAD_LSB +: FIELD_W];
		else if (wr_mode)
			count_r <= wdata[RELOAD_LSB +: FIELD_W];
		else if (restart_ok)
			count_r <= reload_v;
		else if (tick)
		begin
			// The counter wraps to the reload value so underflow repeats each period.
			if (count_r == '0)
				count_r <= reload_v;
			else
				count_r <= count_r - 12'h001;
		end
	end

	// ************************************************
	// Sticky status, set wins over read clear
	// ************************************************
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			unf_r <= 1'b0;
			err_r <= 1'b0;
		end
		else
		begin
			unf_r <= underflow || (unf_r && !rd_stat);
			err_r <= win_err || (err_r && !rd_stat);
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	logic irq_nxt, fault_nxt;
	assign irq_nxt = mode_r[IRQ_EN_BIT] && (underflow || win_err ||
		((unf_r || err_r) && !rd_stat));
	assign fault_nxt = mode_r[RST_EN_BIT] && (underflow || win_err ||
		((unf_r || err_r) && !rd_stat));

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			irq <= 1'b0;
			fault <= 1'b0;
			proc_reset_only <= 1'b0;
		end
		else
		begin
			irq <= irq_nxt;
			fault <= fault_nxt;
			proc_reset_only <= fault_nxt && mode_r[SCOPE_BIT];
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			rdata <= 32'h00000000;
		else if (rd)
		begin
			unique case (addr)
				OFF_WATCHDOG_MODE: rdata <= mode_r;
				OFF_FAULT_STATUS: rdata <= {30'h0, err_r, unf_r};
				default: rdata <= 32'h00000000;
			endcase
		end
		else
			rdata <= 32'h00000000;
	end

	// ************************************************
	// Checks
	// ************************************************
	sequence s_keyed_restart;
		wr && addr == OFF_RESTART_CONTROL && wdata[31:24] == 8'ha5 && wdata[0];
	endsequence

	a_bad_key_ignored: assert property (@(posedge clock) disable iff (srst)
		wr && addr == OFF_RESTART_CONTROL && wdata[31:24] != 8'ha5 && !tick
		|=> $stable(count_r) || count_r == $past(count_r) - 12'h001)
		else $error("bad key changed counter");
	a_restart_load: assert property (@(posedge clock) disable iff (srst)
		s_keyed_restart ##0 (count_r <= window_v) && !wr_mode
		|=> count_r == $past(reload_v))
		else $error("restart did not reload");
	a_mode_locked: assert property (@(posedge clock) disable iff (srst)
		mode_locked_r |=> $stable(mode_r))
		else $error("mode changed after lock");
	a_window_error: assert property (@(posedge clock) disable iff (srst)
		s_keyed_restart ##0 (count_r > window_v) |=> err_r)
		else $error("early restart not flagged");
	a_halt_freeze: assert property (@(posedge clock) disable iff (srst)
		mode_r[DISABLE_BIT] && !wr_mode && !restart_ok |=> $stable(count_r))
		else $error("disabled counter moved");
	a_irq_gate: assert property (@(posedge clock) disable iff (srst)
		!mode_r[IRQ_EN_BIT] && !$past(mode_r[IRQ_EN_BIT]) |-> !irq)
		else $error("irq while disabled");
	a_read_clear: assert property (@(posedge clock) disable iff (srst)
		rd_stat && !underflow && !win_err |=> !unf_r && !err_r && !fault && !irq)
		else $error("status read did not clear");
	a_unf_fault: assert property (@(posedge clock) disable iff (srst)
		underflow && mode_r[RST_EN_BIT] |=> fault && unf_r)
		else $error("underflow without fault");
	a_irq_hold: assert property (@(posedge clock) disable iff (srst)
		(unf_r || err_r) && mode_r[IRQ_EN_BIT] && !rd_stat |=> irq)
		else $error("irq dropped while flag set");

	// ************************************************
	// Further checks on the bus, the counter, the prescaler, the flags and the outputs
	// ************************************************
	// Counts enabled slow pulses since the last tick or prescaler clear.
	// It shadows the prescaler so that a wrong divide ratio shows at once.
	logic [PRESCALE_W:0] gap_r;
	always_ff @(posedge clock)
	begin
		if (srst || prescale_clr || tick)
			gap_r <= '0;
		else if (run && slck_en)
			gap_r <= gap_r + 8'h01;
	end

	sequence s_status_read;
		rd && addr == OFF_FAULT_STATUS;
	endsequence

	sequence s_first_mode_write;
		wr && addr == OFF_WATCHDOG_MODE && !mode_locked_r;
	endsequence

	sequence s_unkeyed_write;
		wr && addr == OFF_RESTART_CONTROL && wdata[KEY_LSB +: 8] != UNLOCK_VALUE;
	endsequence

	sequence s_keyed_no_restart;
		wr && addr == OFF_RESTART_CONTROL && wdata[KEY_LSB +: 8] == UNLOCK_VALUE
			&& !wdata[RESTART_BIT];
	endsequence

	a_unkeyed_no_err: assert property (@(posedge clock) disable iff (srst)
		s_unkeyed_write ##0 !err_r
		|=> !err_r)
		else $error("unkeyed write raised error");

	a_zero_bit_noop: assert property (@(posedge clock) disable iff (srst)
		s_keyed_no_restart ##0 !err_r
		|=> !err_r)
		else $error("restart bit zero raised error");

	a_ctrl_read_zero: assert property (@(posedge clock) disable iff (srst)
		rd && addr == OFF_RESTART_CONTROL
		|=> rdata == 32'h00000000)
		else $error("control read not zero");

	a_mode_first: assert property (@(posedge clock) disable iff (srst)
		s_first_mode_write
		|=> mode_locked_r && mode_r == ($past(wdata) & MODE_MASK))
		else $error("first mode write lost");

	a_mode_readback: assert property (@(posedge clock) disable iff (srst)
		rd && addr == OFF_WATCHDOG_MODE
		|=> rdata == $past(mode_r))
		else $error("mode readback wrong");

	a_mode_reload: assert property (@(posedge clock) disable iff (srst)
		wr_mode
		|=> count_r == $past(wdata[RELOAD_LSB +: FIELD_W]))
		else $error("mode write did not reload");

	a_irq_on_fault: assert property (@(posedge clock) disable iff (srst)
		(underflow || win_err) && mode_r[IRQ_EN_BIT]
		|=> irq)
		else $error("fault without irq");

	a_fault_off: assert property (@(posedge clock) disable iff (srst)
		!mode_r[RST_EN_BIT]
		|=> !fault && !proc_reset_only)
		else $error("fault while reset disabled");

	a_scope_follow: assert property (@(posedge clock) disable iff (srst)
		proc_reset_only == (fault && $past(mode_r[SCOPE_BIT])))
		else $error("reset scope wrong");

	a_window_ok: assert property (@(posedge clock) disable iff (srst)
		s_keyed_restart ##0 (count_r <= window_v) && !err_r
		|=> !err_r)
		else $error("restart in window flagged");

	a_early_no_reload: assert property (@(posedge clock) disable iff (srst)
		s_keyed_restart ##0 (count_r > window_v) && !tick
		|=> $stable(count_r))
		else $error("early restart reloaded");

	a_debug_freeze: assert property (@(posedge clock) disable iff (srst)
		mode_r[DBG_HALT_BIT] && dbg_s2_r && !wr_mode && !restart_ok
		|=> $stable(count_r))
		else $error("counter ran in debug halt");

	a_idle_freeze: assert property (@(posedge clock) disable iff (srst)
		mode_r[IDLE_HALT_BIT] && idle_s2_r && !wr_mode && !restart_ok
		|=> $stable(count_r))
		else $error("counter ran in idle halt");

	a_unf_sticky: assert property (@(posedge clock) disable iff (srst)
		unf_r && !rd_stat
		|=> unf_r)
		else $error("underflow flag lost");

	a_err_sticky: assert property (@(posedge clock) disable iff (srst)
		err_r && !rd_stat
		|=> err_r)
		else $error("error flag lost");

	a_status_read: assert property (@(posedge clock) disable iff (srst)
		s_status_read
		|=> rdata == {30'h0, $past(err_r), $past(unf_r)})
		else $error("status readback wrong");

	a_tick_step: assert property (@(posedge clock) disable iff (srst)
		tick && count_r != 12'h000 && !wr_mode && !restart_ok
		|=> count_r == $past(count_r) - 12'h001)
		else $error("tick did not decrement");

	a_tick_period: assert property (@(posedge clock) disable iff (srst)
		tick
		|-> gap_r == 8'(PRESCALE_DIV - 1))
		else $error("tick period wrong");

	a_gap_bound: assert property (@(posedge clock) disable iff (srst)
		gap_r <= 8'(PRESCALE_DIV - 1))
		else $error("prescaler overran");

	a_clear_tick: assert property (@(posedge clock) disable iff (srst)
		prescale_clr
		|=> !tick)
		else $error("prescaler not cleared");

	a_unf_reload: assert property (@(posedge clock) disable iff (srst)
		underflow
		|=> unf_r && count_r == $past(reload_v))
		else $error("underflow not flagged");

	// With no flag and no new event, both outputs must fall back low.
	a_quiet_outputs: assert property (@(posedge clock) disable iff (srst)
		!unf_r && !err_r && !underflow && !win_err
		|=> !irq && !fault)
		else $error("output high without flag");
endmodule : windowed_watchdog_timer
`default_nettype wire

// [src/wdog_pkg.sv]
// Package with register map, field positions, reset values and timing for the watchdog.
`default_nettype none
package wdog_pkg;
	localparam logic [3:0] OFF_RESTART_CONTROL = 4'h0;
	localparam logic [3:0] OFF_WATCHDOG_MODE = 4'h4;
	localparam logic [3:0] OFF_FAULT_STATUS = 4'h8;
	localparam logic [7:0] UNLOCK_VALUE = 8'ha5;
	localparam int KEY_LSB = 24;
	localparam int RESTART_BIT = 0;
	localparam int RELOAD_LSB = 0;
	localparam int WINDOW_LSB = 16;
	localparam int FIELD_W = 12;
	localparam int IRQ_EN_BIT = 12;
	localparam int RST_EN_BIT = 13;
	localparam int SCOPE_BIT = 14;
	localparam int DISABLE_BIT = 15;
	localparam int DBG_HALT_BIT = 28;
	localparam int IDLE_HALT_BIT = 29;
	localparam int UNF_BIT = 0;
	localparam int ERR_BIT = 1;
	localparam logic [31:0] MODE_RESET = 32'h3fff2fff;
	localparam logic [31:0] MODE_MASK = 32'h3fffffff;
	localparam int PRESCALE_DIV = 128;
	localparam int PRESCALE_W = 7;
endpackage : wdog_pkg
`default_nettype wire

// [src/slow_tick.sv]
// Divide-by-128 prescaler on slow clock enable pulses, restartable.
`default_nettype none
module slow_tick
	import wdog_pkg::*;
(
	input wire logic clock, // System clock.
	input wire logic srst, // Synchronous reset.
	input wire logic slck_en, // One slow clock period pulse.
	input wire logic run, // Counting allowed.
	input wire logic restart, // Clear the prescaler.
	output logic tick // One pulse per 128 slow periods.
);
	logic [PRESCALE_W-1:0] div_r;
	always_ff @(posedge clock)
	begin
		if (srst || restart)
			div_r <= '0;
		else if (run && slck_en)
			div_r <= div_r + 7'h01;
	end
	assign tick = run && slck_en && (div_r == 7'(PRESCALE_DIV - 1));
endmodule : slow_tick
`default_nettype wire

// [verification/windowed_watchdog_timer_tb.sv]
// Self-checking bench for the windowed watchdog timer.
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD %0t value mismatch", $time); end end
module windowed_watchdog_timer_tb
	import wdog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, srst = 1'b1, slck_en = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
	logic debug_state = 1'b0, idle_state = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, key;
	logic irq, fault, proc_reset_only;
	logic [31:0] expq [$];
	logic [31:0] modes [4] = '{32'h0002b002, 32'h10023002, 32'h20023002, 32'h00022002};
	int n_errors = 0, n_compared = 0, cycles = 0, i, k;

	windowed_watchdog_timer DUT (.clock(clock), .srst(srst), .slck_en(slck_en),
		.debug_state(debug_state), .idle_state(idle_state), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .fault(fault),
		.proc_reset_only(proc_reset_only));

	initial
	begin
		forever #4 clock = ~clock;
	end

	// ********************************
	// Bus tasks and closing report
	// ********************************
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		expq.push_back(e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
	endtask : rd_reg

	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick

	task automatic do_reset;
		@(posedge clock);
		srst <= 1'b1;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
	endtask : do_reset

	task automatic finish_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test

	// Read data stand only in the cycle after the strobe, so the check samples exactly there.
	always @(posedge clock)
	begin
		rd_d <= rd;
		if (rd_d)
			`CHK(rdata, expq.pop_front())
		cycles++;
		if (cycles == 30000)
		begin
			n_errors++;
			finish_test();
		end
	end

	// ********************************
	// Main sequence
	// ********************************
	initial
	begin
		void'($urandom(32'hecec));
		do_reset();
		rd_reg(OFF_WATCHDOG_MODE, MODE_RESET);
		rd_reg(OFF_FAULT_STATUS, 32'h0);
		rd_reg(OFF_RESTART_CONTROL, 32'h0);
		rd_reg(4'hc, 32'h0);
		wr_reg(OFF_WATCHDOG_MODE, 32'h00107020);
		wr_reg(OFF_WATCHDOG_MODE, 32'h00000fff);
		rd_reg(OFF_WATCHDOG_MODE, 32'h00107020);
		key = $urandom;
		if (key[31:24] == UNLOCK_VALUE)
			key[31] = ~key[31];
		wr_reg(OFF_RESTART_CONTROL, key | 32'h1);
		wr_reg(OFF_RESTART_CONTROL, {UNLOCK_VALUE, 24'h0});
		tick(3);
		`CHK(fault, 1'b0)
		rd_reg(OFF_FAULT_STATUS, 32'h0);
		// The counter is still above the window here, so this restart is an error.
		wr_reg(OFF_RESTART_CONTROL, {UNLOCK_VALUE, 24'h1});
		tick(3);
		`CHK({irq, fault, proc_reset_only}, 3'b111)
		rd_reg(OFF_FAULT_STATUS, 32'h2);
		tick(3);
		`CHK({irq, fault}, 2'b00)
		tick(20 * PRESCALE_DIV);
		wr_reg(OFF_RESTART_CONTROL, {UNLOCK_VALUE, 24'h1});
		for (i = 0; i < 5000 && irq !== 1'b1; i++)
			@(negedge clock);
		`CHK(i > 33 * PRESCALE_DIV - 5 && i < 33 * PRESCALE_DIV + 5, 1'b1)
		rd_reg(OFF_FAULT_STATUS, 32'h1);
		// Disable, debug halt, idle halt, then a free run with the interrupt masked.
		for (k = 0; k < 4; k++)
		begin
			do_reset();
			debug_state <= (k != 0);
			idle_state <= (k != 0);
			wr_reg(OFF_WATCHDOG_MODE, modes[k]);
			tick(1000);
			`CHK(fault, k == 3)
			`CHK(irq, 1'b0)
			@(posedge clock);
			debug_state <= 1'b0;
			idle_state <= 1'b0;
			for (i = 0; i < 1000 && fault !== 1'b1; i++)
				@(negedge clock);
			`CHK(fault, k != 0)
			`CHK(proc_reset_only, 1'b0)
		end
		finish_test();
	end
endmodule : windowed_watchdog_timer_tb
`default_nettype wire
